// ---- core/rwwt_defines.vh ----
`ifndef RWWT_DEFINES_VH
`define RWWT_DEFINES_VH
// Register byte offsets.
`define RWWT_OFF_WDCTL      8'h00
`define RWWT_OFF_WUT_CTL    8'h04
`define RWWT_OFF_WUT_PERIOD 8'h08
`define RWWT_OFF_STATUS     8'h0c
`define RWWT_OFF_MASK       8'h10
`define RWWT_OFF_CAUSE      8'h14
`define RWWT_OFF_WDCNT      8'h18
`define RWWT_OFF_WUTCNT     8'h1c
// watchdog_control_reg fields.
`define RWWT_WD_RESTART     0
`define RWWT_WD_INT_EN      1
`define RWWT_WD_SEL_LO      2
`define RWWT_WD_SEL_HI      3
`define RWWT_WD_RST_EN      4
`define RWWT_WD_PIN_DIS     5
`define RWWT_WD_FLAG        6
// Wake-up control fields.
`define RWWT_WU_EN          0
`define RWWT_WU_RING        1
`define RWWT_WU_INT_EN      2
// Status / mask fields.
`define RWWT_ST_WD          0
`define RWWT_ST_WU          1
// Timing.
`define RWWT_WD_EARLY       22'h000200
`define RWWT_WD_PER_SEL0    22'h001000
`define RWWT_WD_PER_SEL1    22'h008000
`define RWWT_WD_PER_SEL2    22'h040000
`define RWWT_WD_PER_SEL3    22'h200000
`define RWWT_SYS_RST_LEN    16
`define RWWT_RESET_VECTOR   16'h8000
`define RWWT_RING_HZ        32'h00001f40
`define RWWT_CLK_HZ         32'h00989680
`define RWWT_RING_DIV       (`RWWT_CLK_HZ / `RWWT_RING_HZ)
`define RWWT_WUT_WIDTH      20
`endif

// ---- core/rwwt_sync.v ----
`timescale 1ns/10ps
module rwwt_sync (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Asynchronous level in, synchronised out
  input  wire d_in,
  output wire q_out
);
  reg meta_r;
  reg sync_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule // rwwt_sync

// ---- core/rwwt_top.v ----
// Behaviour
// - A watchdog reset sets a readable watchdog reset flag.
// - After a watchdog reset, fetching starts at address 8000h.
// - A low external reset pin holds reset; after release execution starts at 8000h.
// - The reset pin works after power-on and becomes plain I/O when disabled.
// - The watchdog is a free-running restartable counter that resets the system at terminal count.
// - Four timeouts from 2^12 to 2^21 clocks are selectable.
// - The watchdog interrupt rises exactly 512 clocks before the reset.
// - The interrupt is optional; the reset happens regardless.
// - A 20-bit wake-up timer raises an interrupt or ends stop mode on expiry.
// - The wake-up clock is the system clock or the 8 kHz ring oscillator.
// - In stop mode the wake-up timer counts only ring oscillator ticks.
// - Wake-up expiry ends stop mode and execution resumes on the ring oscillator.
// - Each event sets its flag even when its interrupt is disabled.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "rwwt_defines.vh"
module rwwt_top #(
  parameter WUT_WIDTH  = `RWWT_WUT_WIDTH,
  parameter SYS_RST_LEN = `RWWT_SYS_RST_LEN
) (
  // Clock and power-on reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // External reset pin, shared with general-purpose I/O
  input  wire        reset_pin_n,
  output wire        reset_pin_gpio,
  // Power state
  input  wire        stop_req,
  output reg         stop_mode_r,
  output reg         run_on_ring_r,
  // System reset and fetch address
  output reg         sys_reset_r,
  output reg  [15:0] fetch_addr_r,
  // Interrupt
  output wire        irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]            wdctl_r;
  reg  [2:0]            wuctl_r;
  reg  [WUT_WIDTH-1:0]  wuper_r;
  reg  [1:0]            status_r;
  reg  [1:0]            mask_r;
  reg  [1:0]            cause_r;
  reg  [21:0]           wdcnt_r;
  reg  [4:0]            hold_r;
  wire                  pin_s;
  wire [WUT_WIDTH-1:0]  wucnt;
  wire                  wu_expire;
  wire                  ext_rst;
  wire                  wd_rst_pulse;
  wire                  wd_warn;
  wire [21:0]           wd_limit;
  reg  [31:0]           rd_mux;

  function [21:0] wd_period;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    wd_period = `RWWT_WD_PER_SEL0;
        2'h1:    wd_period = `RWWT_WD_PER_SEL1;
        2'h2:    wd_period = `RWWT_WD_PER_SEL2;
        default: wd_period = `RWWT_WD_PER_SEL3;
      endcase
    end
  endfunction

  // Only aligned words inside the map are answered with OKAY.
  function addr_ok;
    input [7:0] addr;
    begin
      addr_ok = (addr[1:0] == 2'b00) && (addr <= `RWWT_OFF_WUTCNT);
    end
  endfunction

  rwwt_sync i_rwwt_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_in    (reset_pin_n),
    .q_out   (pin_s)
  );

  // Once disabled the pin only reports its level as general-purpose input.
  assign ext_rst        = !wdctl_r[`RWWT_WD_PIN_DIS] && !pin_s;
  assign reset_pin_gpio = pin_s;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg        aw_got_r;
  reg        w_got_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  // A write waits until address and data are both held, so either may arrive first.
  wire       do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  wire       wr_hit   = do_write && addr_ok(awaddr_r);
  wire       rd_take  = s_axi_arvalid && !s_axi_rvalid;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    case (s_axi_araddr)
      `RWWT_OFF_WDCTL:      rd_mux = {24'h000000, 1'b0, cause_r[0], wdctl_r[5:1], 1'b0};
      `RWWT_OFF_WUT_CTL:    rd_mux = {29'h00000000, wuctl_r};
      `RWWT_OFF_WUT_PERIOD: rd_mux = {{(32-WUT_WIDTH){1'b0}}, wuper_r};
      `RWWT_OFF_STATUS:     rd_mux = {30'h00000000, status_r};
      `RWWT_OFF_MASK:       rd_mux = {30'h00000000, mask_r};
      `RWWT_OFF_CAUSE:      rd_mux = {30'h00000000, cause_r};
      `RWWT_OFF_WDCNT:      rd_mux = {10'h000, wdcnt_r};
      `RWWT_OFF_WUTCNT:     rd_mux = {{(32-WUT_WIDTH){1'b0}}, wucnt};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // Read data is registered at the address handshake, so it stands until it is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Configuration survives the watchdog reset; only power-on clears it, so that
  // the reset cause and pin mode stay readable afterwards.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdctl_r <= 8'h00;
      wuctl_r <= 3'b000;
      wuper_r <= {WUT_WIDTH{1'b0}};
      mask_r  <= 2'b00;
    end else if (wr_hit) begin
      case (awaddr_r)
        `RWWT_OFF_WDCTL:      wdctl_r <= {2'b00, wdata_r[5:1], 1'b0};
        `RWWT_OFF_WUT_CTL:    wuctl_r <= wdata_r[2:0];
        `RWWT_OFF_WUT_PERIOD: wuper_r <= wdata_r[WUT_WIDTH-1:0];
        `RWWT_OFF_MASK:       mask_r  <= wdata_r[1:0];
        default:              wdctl_r <= wdctl_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  wire wd_restart = wr_hit && (awaddr_r == `RWWT_OFF_WDCTL) && wdata_r[`RWWT_WD_RESTART];
  assign wd_limit     = wd_period(wdctl_r[`RWWT_WD_SEL_HI:`RWWT_WD_SEL_LO]);
  // The flag lands one clock after the match, so the match sits one count lower to put
  // the warning exactly the early-warning distance ahead of the reset.
  assign wd_warn      = (wdcnt_r == wd_limit - `RWWT_WD_EARLY - 22'h000001);
  assign wd_rst_pulse = wdctl_r[`RWWT_WD_RST_EN] && (wdcnt_r == wd_limit - 22'h000001);

  // The count clears and stays at zero in stop mode, since its clock is halted there.
  always @(posedge aclk) begin
    if (!aresetn || sys_reset_r || wd_restart || stop_mode_r)
      wdcnt_r <= 22'h000000;
    else if (wdcnt_r == wd_limit - 22'h000001)
      wdcnt_r <= 22'h000000;
    else
      wdcnt_r <= wdcnt_r + 22'h000001;
  end

  // Set wins over a write-one-to-clear landing in the same cycle.
  wire [1:0] st_set = {wu_expire, wd_warn && !sys_reset_r};
  wire [1:0] st_clr = (wr_hit && awaddr_r == `RWWT_OFF_STATUS) ? wdata_r[1:0] : 2'b00;
  wire [1:0] ca_clr = (wr_hit && awaddr_r == `RWWT_OFF_CAUSE) ? wdata_r[1:0] : 2'b00;

  // Cause bits ignore the system reset, so software can still read why it happened.
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 2'b00;
      cause_r  <= 2'b00;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
      cause_r  <= (cause_r & ~ca_clr) | {ext_rst, wd_rst_pulse};
    end
  end

  // Enable bits sit in the control registers; the mask gates the single output.
  assign irq = |(status_r & mask_r & {wuctl_r[`RWWT_WU_INT_EN], wdctl_r[`RWWT_WD_INT_EN]});

  // ----------------------------------------------------------------
  // System reset and restart address
  // ----------------------------------------------------------------
  // A pin reset holds two clocks past the synchronised pin's return; a watchdog reset holds for
  // SYS_RST_LEN + 1 clocks so that the whole system settles before fetching again.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_r  <= 1'b1;
      hold_r       <= SYS_RST_LEN[4:0];
      fetch_addr_r <= `RWWT_RESET_VECTOR;
    end else begin
      if (ext_rst) begin
        sys_reset_r <= 1'b1;
        hold_r      <= 5'h01;
      end else if (wd_rst_pulse) begin
        sys_reset_r <= 1'b1;
        hold_r      <= SYS_RST_LEN[4:0];
      end else if (hold_r != 5'h00) begin
        hold_r <= hold_r - 5'h01;
      end else begin
        sys_reset_r <= 1'b0;
      end
      if (sys_reset_r)
        fetch_addr_r <= `RWWT_RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up timer and stop mode
  // ----------------------------------------------------------------
  // A system reset restarts the wake-up timer together with the rest of the system.
  rwwt_wakeup #(
    .WIDTH    (WUT_WIDTH),
    .RING_DIV (`RWWT_RING_DIV)
  ) i_rwwt_wakeup (
    .aclk      (aclk),
    .rst_n     (aresetn && !sys_reset_r),
    .enable    (wuctl_r[`RWWT_WU_EN]),
    .use_ring  (wuctl_r[`RWWT_WU_RING]),
    .stop_mode (stop_mode_r),
    .period    (wuper_r),
    .count_r   (wucnt),
    .expire_r  (wu_expire)
  );

  always @(posedge aclk) begin
    if (!aresetn || sys_reset_r) begin
      stop_mode_r   <= 1'b0;
      run_on_ring_r <= 1'b0;
    // The core stays on the ring clock after a wake-up until the next system reset.
    end else if (stop_mode_r && wu_expire) begin
      stop_mode_r   <= 1'b0;
      run_on_ring_r <= 1'b1;
    end else if (stop_req) begin
      stop_mode_r <= 1'b1;
    end
  end
endmodule // rwwt_top

// ---- core/rwwt_wakeup.v ----
`timescale 1ns/10ps
`include "rwwt_defines.vh"
module rwwt_wakeup #(
  parameter WIDTH   = `RWWT_WUT_WIDTH,
  parameter RING_DIV = `RWWT_RING_DIV
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             rst_n,
  // Control
  input  wire             enable,
  input  wire             use_ring,
  input  wire             stop_mode,
  input  wire [WIDTH-1:0] period,
  // State
  output reg  [WIDTH-1:0] count_r,
  output reg              expire_r
);
  reg  [15:0] div_r;
  wire        ring_tick = (div_r == 16'h0000);
  wire        tick;

  always @(posedge aclk) begin
    if (!rst_n)
      div_r <= 16'h0000;
    else if (ring_tick)
      div_r <= RING_DIV[15:0] - 16'h0001;
    else
      div_r <= div_r - 16'h0001;
  end

  // In stop mode the system clock is gone, so only the ring tick counts.
  assign tick = (use_ring || stop_mode) ? ring_tick : !stop_mode;

  always @(posedge aclk) begin
    if (!rst_n || !enable) begin
      count_r  <= {WIDTH{1'b0}};
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (tick) begin
        if (count_r >= period) begin
          count_r  <= {WIDTH{1'b0}};
          expire_r <= 1'b1;
        end else begin
          count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // rwwt_wakeup

// ---- testbench/rwwt_properties.sv ----
`timescale 1ns/10ps
module rwwt_properties #(
  parameter SYS_RST_LEN = 16
) (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Power and reset state
  input wire        stop_mode_r,
  input wire        run_on_ring_r,
  input wire        sys_reset_r,
  input wire [15:0] fetch_addr_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer missing");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
  chk_por_hold: assert property ($rose(aresetn) |-> sys_reset_r [*8])
    else $error("system reset short after power-on");
  chk_reset_len: assert property ($rose(sys_reset_r) |-> sys_reset_r [*8])
    else $error("system reset pulse short");
  chk_fetch_vector: assert property ($fell(sys_reset_r) |-> fetch_addr_r == 16'h8000)
    else $error("fetch address wrong after reset");
  chk_stop_exit: assert property ($fell(stop_mode_r) && !sys_reset_r |-> run_on_ring_r)
    else $error("stop exit not on ring clock");
endmodule // rwwt_properties

bind rwwt_top rwwt_properties #(.SYS_RST_LEN(SYS_RST_LEN)) i_rwwt_properties (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .stop_mode_r, .run_on_ring_r, .sys_reset_r, .fetch_addr_r);

// ---- testbench/rwwt_reset_src.sv ----
`timescale 1ns/10ps
module rwwt_reset_src (
  // Clock and pulse request
  input wire       aclk,
  input wire       start,
  input wire [7:0] pulse_len,
  // Reset pin, pulled up while released
  output wire      reset_pin_n
);
  reg [7:0] left_r = 8'h00;
  // The pin is low for exactly pulse_len clocks, then returns to the pull-up level.
  assign reset_pin_n = (left_r == 8'h00);
  always @(posedge aclk) begin
    if (start)
      left_r <= pulse_len;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
endmodule // rwwt_reset_src

// ---- testbench/rwwt_top_tb.sv ----
`timescale 1ns/10ps
`include "rwwt_defines.vh"
module rwwt_top_tb;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
  // Waits on settled values at the falling edge, then resumes on a rising edge.
  `define WAITF(c, t) begin n = 0; do begin @(negedge aclk); n++; end \
    while (!(c) && n < 9000); if (n >= 9000) mismatches++; t = cyc; @(posedge aclk); end
  logic        aclk = 0, aresetn = 0, stop_req = 0, start = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, ta, tw, tb, tr;
  logic        pin_n, gpio, stop_mode_r, ring_r, sys_reset_r, irq;
  logic [15:0] fetch_addr_r;
  int          cyc = 0, n, t0, t1, t2, mismatches = 0, total_checks = 0;

  rwwt_top #(.SYS_RST_LEN(16)) i_rwwt_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .reset_pin_n(pin_n), .reset_pin_gpio(gpio),
    .stop_req(stop_req), .stop_mode_r(stop_mode_r), .run_on_ring_r(ring_r),
    .sys_reset_r(sys_reset_r), .fetch_addr_r(fetch_addr_r), .irq(irq));
  rwwt_reset_src i_rwwt_reset_src (.aclk(aclk), .start(start), .pulse_len(8'h14),
    .reset_pin_n(pin_n));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask
  task automatic pulse;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RWWT_OFF_WDCTL);
    `CHK(d, 32'h0)
    rd(8'h40);
    `CHK(r, 2'b10)
    // The count only starts once the power-on hold is over, so restart after it.
    `WAITF(!sys_reset_r, t1)
    wr(`RWWT_OFF_WDCTL, 32'h13);
    t0 = cyc;
    wr(`RWWT_OFF_STATUS, 32'h3);
    wr(`RWWT_OFF_MASK, 32'h1);
    `WAITF(irq, t1)
    `WAITF(sys_reset_r, t2)
    `CHK(t2 - t1, 512)
    `CHK(t2 - t0 > 4080 && t2 - t0 < 4100, 1'b1)
    `WAITF(!sys_reset_r, t1)
    `CHK(fetch_addr_r, 16'h8000)
    rd(`RWWT_OFF_CAUSE);
    `CHK(d[0], 1'b1)
    rd(`RWWT_OFF_WDCTL);
    `CHK(d[6], 1'b1)
    wr(`RWWT_OFF_CAUSE, 32'h1);
    rd(`RWWT_OFF_CAUSE);
    `CHK(d[0], 1'b0)
    // The interrupt stays off here, yet the warning flag and the reset still come.
    wr(`RWWT_OFF_MASK, 32'h0);
    wr(`RWWT_OFF_WDCTL, 32'h11);
    t0 = cyc;
    wr(`RWWT_OFF_STATUS, 32'h3);
    `WAITF(sys_reset_r, t2)
    `CHK(t2 - t0 > 4080 && t2 - t0 < 4100, 1'b1)
    `WAITF(!sys_reset_r, t1)
    wr(`RWWT_OFF_WDCTL, 32'h1);
    wr(`RWWT_OFF_STATUS, 32'h3);
    repeat (4200) @(posedge aclk);
    rd(`RWWT_OFF_STATUS);
    `CHK(d[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(`RWWT_OFF_CAUSE, 32'h3);
    pulse;
    `WAITF(sys_reset_r, t1)
    `WAITF(!sys_reset_r, t2)
    `CHK(t2 - t1 > 20, 1'b1)
    `CHK(fetch_addr_r, 16'h8000)
    rd(`RWWT_OFF_CAUSE);
    `CHK(d[1], 1'b1)
    wr(`RWWT_OFF_WDCTL, 32'h20);
    pulse;
    repeat (10) @(posedge aclk);
    `CHK(gpio, 1'b0)
    `CHK(sys_reset_r, 1'b0)
    repeat (30) @(posedge aclk);
    `CHK(gpio, 1'b1)
    wr(`RWWT_OFF_WUT_PERIOD, 32'h9);
    wr(`RWWT_OFF_STATUS, 32'h3);
    wr(`RWWT_OFF_MASK, 32'h2);
    wr(`RWWT_OFF_WUT_CTL, 32'h5);
    `WAITF(irq, t1)
    wr(`RWWT_OFF_STATUS, 32'h2);
    `WAITF(irq, t2)
    `CHK(t2 - t1, 10)
    wr(`RWWT_OFF_WUT_CTL, 32'h0);
    wr(`RWWT_OFF_WUT_PERIOD, 32'h1);
    wr(`RWWT_OFF_WUT_CTL, 32'h3);
    stop_req <= 1'b1;
    `WAITF(stop_mode_r, t1)
    stop_req <= 1'b0;
    `WAITF(!stop_mode_r, t2)
    `CHK(ring_r, 1'b1)
    `CHK(t2 - t1 > 1200 && t2 - t1 < 2600, 1'b1)
    complete_run;
  end
endmodule // rwwt_top_tb
